// File: inc/iopc_consts.vh
// constants for the i/o port line configuration block
`ifndef IOPC_CONSTS_VH
`define IOPC_CONSTS_VH

// register indices, byte address is four times the index
`define IOPC_IDX_VAL_A 8'hc0
`define IOPC_IDX_VAL_B 8'hc1
`define IOPC_IDX_VAL_C 8'hc3
`define IOPC_IDX_DIR_A 8'hc4
`define IOPC_IDX_DIR_B 8'hc5
`define IOPC_IDX_DIR_C 8'hc6
`define IOPC_IDX_OPT_A 8'hcc
`define IOPC_IDX_OPT_B 8'hce
`define IOPC_IDX_OPT_C 8'hcf
`define IOPC_IDX_TRIG 8'hd0

// bus geometry
`define IOPC_ADDR_W 10
`define IOPC_IDX_LSB 2
`define IOPC_IDX_MSB 9

// reset values
`define IOPC_PORT_RST 8'h00
`define IOPC_TRIG_RST 6'h00
`define IOPC_RDATA_RST 32'h00000000

// trigger mode codes, two bits per port
`define IOPC_TRIG_FALL 2'h0
`define IOPC_TRIG_RISE 2'h1
`define IOPC_TRIG_LOW 2'h2

// trigger field positions
`define IOPC_TRIG_A_LSB 0
`define IOPC_TRIG_B_LSB 2
`define IOPC_TRIG_C_LSB 4

// line index of alternate function lines in the flat 24-line vector
`define IOPC_LINE_PA5 5
`define IOPC_LINE_PA6 6
`define IOPC_LINE_PA7 7
`define IOPC_LINE_PB0 8
`define IOPC_LINE_PB1 9
`define IOPC_LINE_PB6 14
`define IOPC_LINE_PB7 15

// implemented lines and analog capable lines
`define IOPC_PRESENT_MASK 24'hfffffc
`define IOPC_ANALOG_MASK 24'hf0ff00

`endif

// File: rtl/iopc_line.v
// one port line: mode decode, pin drive and input event detection
`timescale 1ns/100ps
module iopc_line #(
  parameter PRESENT = 1'b1,
  parameter ANALOG_OK = 1'b0
) (
  // clock and reset
  input wire core_clk,
  input wire rstn,
  // line configuration bits
  input wire dir,
  input wire opt,
  input wire dat,
  // pin level
  input wire pin_in,
  // alternate function hooks
  input wire force_en,
  input wire force_val,
  input wire sub_en,
  input wire sub_val,
  input wire od_en,
  input wire od_val,
  // pin controls
  output reg pin_out,
  output reg pin_oe_n,
  output wire pull_up_en,
  output wire analog_en,
  output wire irq_route,
  // read back and events
  output wire read_val,
  output wire ev_fall,
  output wire ev_rise,
  output wire ev_low
);
  reg prev_q;
  wire in_mode;
  wire out_bit;

  assign in_mode = ~dir & ~force_en;
  assign pull_up_en = PRESENT & in_mode & ~dat; // (R1) (R3)
  assign irq_route = PRESENT & in_mode & opt & ~dat; // (R3)
  assign analog_en = PRESENT & ANALOG_OK & in_mode & opt & dat; // (R4)
  assign out_bit = sub_en ? sub_val : dat; // (R19)
  assign read_val = PRESENT & (dir ? dat : pin_in); // (R9) (R16) (R18)

  // input edge and level events, only when routed to interrupts
  always @(posedge core_clk) begin
    if (!rstn) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= pin_in;
    end
  end
  assign ev_fall = irq_route & prev_q & ~pin_in; // (R7)
  assign ev_rise = irq_route & ~prev_q & pin_in; // (R7)
  assign ev_low = irq_route & ~pin_in; // (R7)

  // pin drive, enable low while driving
  always @* begin
    pin_out = 1'b0;
    pin_oe_n = 1'b1;
    if (!PRESENT) begin
      pin_oe_n = 1'b1;
    end else if (force_en) begin
      pin_out = force_val; // (R14)
      pin_oe_n = 1'b0;
    end else if (in_mode) begin
      pin_oe_n = 1'b1; // (R2)
    end else if (opt) begin
      pin_out = out_bit; // (R6) (R17)
      pin_oe_n = 1'b0;
    end else begin
      pin_out = 1'b0;
      pin_oe_n = ~(~out_bit | (od_en & ~od_val)); // (R5) (R17)
    end
  end
endmodule // iopc_line

// File: rtl/iopc_top.v
// i/o port line configuration with avalon-mm register slave
//
// Contract
// (R1) dir 0, opt 0, data 0: input with pull-up, no interrupt.
// (R2) dir 0, opt 0, data 1: high-impedance input, no pull-up or interrupt.
// (R3) dir 0, opt 1, data 0: input with pull-up routed to interrupts.
// (R4) dir 0, opt 1, data 1: analog input on analog capable lines.
// (R5) dir 1, opt 0: open-drain output from the data latch.
// (R6) dir 1, opt 1: push-pull output from the data latch.
// (R7) interrupt inputs trigger on falling, rising or low level, per port.
// (R8) software selects at most one analog input at a time.
// (R9) value register reads pin levels for input lines.
// (R10) bit operations read whole register then write back all eight bits.
// (R11) software uses a ram copy for ports with inputs.
// (R12) software masks missing bits after whole register operations.
// (R13) software changes modes only through safe transitions.
// (R14) pulse output enable high puts pwm on port b line 7.
// (R15) port b line 6 always feeds the reload timer input.
// (R16) serial input and slave clock lines readable as inputs any time.
// (R17) serial out transmits in open drain; push-pull shows latch only.
// (R18) uart receive line readable as input any time.
// (R19) uart transmit pin shows latch while no transmission active.
// (R20) reset clears all port registers: inputs with pull-up.
// (R21) each port has value, direction and option byte registers.
// (R22) writes affect pins the cycle after, each line decoded alone.
`timescale 1ns/100ps
`include "iopc_consts.vh"
module iopc_top #(
  parameter NUM_LINES = 24,
  parameter PRESENT_MASK = `IOPC_PRESENT_MASK,
  parameter ANALOG_MASK = `IOPC_ANALOG_MASK
) (
  // clock and reset
  input wire core_clk,
  input wire rstn,
  // avalon-mm slave
  input wire [`IOPC_ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // port pins, lines a0..a7, b0..b7, c0..c7
  input wire [NUM_LINES-1:0] pin_in,
  output wire [NUM_LINES-1:0] pin_out,
  output wire [NUM_LINES-1:0] pin_oe_n,
  output wire [NUM_LINES-1:0] pull_up_en,
  output wire [NUM_LINES-1:0] analog_sel,
  output wire [NUM_LINES-1:0] irq_route,
  // per port interrupt requests, a b c
  output reg [2:0] port_event_q,
  // reload timer
  input wire pulse_output_enable,
  input wire pwm_out,
  output reg reload_timer_in_pin_q,
  // synchronous serial
  input wire spi_out_en,
  input wire spi_out_bit,
  output reg spi_sin_q,
  output reg spi_sclk_q,
  // uart
  input wire uart_tx_active,
  input wire uart_tx_bit,
  output reg uart_rx_q
);

  // picks the event of one line for the port trigger mode
  function trig_sel;
    input [1:0] mode;
    input fall;
    input rise;
    input low;
    begin
      case (mode)
        `IOPC_TRIG_FALL: trig_sel = fall;
        `IOPC_TRIG_RISE: trig_sel = rise;
        `IOPC_TRIG_LOW: trig_sel = low;
        default: trig_sel = 1'b0;
      endcase
    end
  endfunction

  // ---- register state
  reg [7:0] val_a_q;
  reg [7:0] val_b_q;
  reg [7:0] val_c_q;
  reg [7:0] dir_a_q;
  reg [7:0] dir_b_q;
  reg [7:0] dir_c_q;
  reg [7:0] opt_a_q;
  reg [7:0] opt_b_q;
  reg [7:0] opt_c_q;
  reg [5:0] trig_q;
  reg ack_q;
  reg [7:0] rd_byte;

  wire [7:0] idx;
  wire req;
  wire wr_en;
  wire rd_en;
  wire [7:0] wbyte;

  wire [NUM_LINES-1:0] val_all;
  wire [NUM_LINES-1:0] dir_all;
  wire [NUM_LINES-1:0] opt_all;
  wire [NUM_LINES-1:0] read_all;
  wire [NUM_LINES-1:0] ev_fall;
  wire [NUM_LINES-1:0] ev_rise;
  wire [NUM_LINES-1:0] ev_low;
  wire [NUM_LINES-1:0] ev_sel;
  wire [NUM_LINES-1:0] force_en_v;
  wire [NUM_LINES-1:0] force_val_v;
  wire [NUM_LINES-1:0] sub_en_v;
  wire [NUM_LINES-1:0] sub_val_v;
  wire [NUM_LINES-1:0] od_en_v;
  wire [NUM_LINES-1:0] od_val_v;

  // ---- bus handshake: one wait cycle, then the access completes
  assign idx = avs_address[`IOPC_IDX_MSB:`IOPC_IDX_LSB];
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign wr_en = avs_write & ack_q & avs_byteenable[0];
  assign rd_en = avs_read & ~ack_q;
  assign wbyte = avs_writedata[7:0];

  always @(posedge core_clk) begin
    if (!rstn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // ---- register writes, each a whole byte
  always @(posedge core_clk) begin
    if (!rstn) begin
      val_a_q <= `IOPC_PORT_RST; // (R20)
      val_b_q <= `IOPC_PORT_RST; // (R20)
      val_c_q <= `IOPC_PORT_RST; // (R20)
      dir_a_q <= `IOPC_PORT_RST; // (R20)
      dir_b_q <= `IOPC_PORT_RST; // (R20)
      dir_c_q <= `IOPC_PORT_RST; // (R20)
      opt_a_q <= `IOPC_PORT_RST; // (R20)
      opt_b_q <= `IOPC_PORT_RST; // (R20)
      opt_c_q <= `IOPC_PORT_RST; // (R20)
      trig_q <= `IOPC_TRIG_RST;
    end else if (wr_en) begin
      case (idx)
        `IOPC_IDX_VAL_A: val_a_q <= wbyte & PRESENT_MASK[7:0]; // (R10) (R21)
        `IOPC_IDX_VAL_B: val_b_q <= wbyte & PRESENT_MASK[15:8]; // (R10) (R21)
        `IOPC_IDX_VAL_C: val_c_q <= wbyte & PRESENT_MASK[23:16]; // (R10) (R21)
        `IOPC_IDX_DIR_A: dir_a_q <= wbyte & PRESENT_MASK[7:0]; // (R21)
        `IOPC_IDX_DIR_B: dir_b_q <= wbyte & PRESENT_MASK[15:8]; // (R15) (R21)
        `IOPC_IDX_DIR_C: dir_c_q <= wbyte & PRESENT_MASK[23:16]; // (R21)
        `IOPC_IDX_OPT_A: opt_a_q <= wbyte & PRESENT_MASK[7:0]; // (R21)
        `IOPC_IDX_OPT_B: opt_b_q <= wbyte & PRESENT_MASK[15:8]; // (R21)
        `IOPC_IDX_OPT_C: opt_c_q <= wbyte & PRESENT_MASK[23:16]; // (R21)
        `IOPC_IDX_TRIG: trig_q <= wbyte[5:0]; // (R7)
        default: trig_q <= trig_q;
      endcase
    end
  end

  // ---- read mux, unmapped indices read zero
  always @* begin
    case (idx)
      `IOPC_IDX_VAL_A: rd_byte = read_all[7:0]; // (R9)
      `IOPC_IDX_VAL_B: rd_byte = read_all[15:8]; // (R9)
      `IOPC_IDX_VAL_C: rd_byte = read_all[23:16]; // (R9)
      `IOPC_IDX_DIR_A: rd_byte = dir_a_q;
      `IOPC_IDX_DIR_B: rd_byte = dir_b_q;
      `IOPC_IDX_DIR_C: rd_byte = dir_c_q;
      `IOPC_IDX_OPT_A: rd_byte = opt_a_q;
      `IOPC_IDX_OPT_B: rd_byte = opt_b_q;
      `IOPC_IDX_OPT_C: rd_byte = opt_c_q;
      `IOPC_IDX_TRIG: rd_byte = {2'h0, trig_q};
      default: rd_byte = 8'h00;
    endcase
  end

  always @(posedge core_clk) begin
    if (!rstn) begin
      avs_readdata <= `IOPC_RDATA_RST;
    end else if (rd_en) begin
      avs_readdata <= {24'h000000, rd_byte};
    end
  end

  // ---- flat line vectors
  assign val_all = {val_c_q, val_b_q, val_a_q};
  assign dir_all = {dir_c_q, dir_b_q, dir_a_q};
  assign opt_all = {opt_c_q, opt_b_q, opt_a_q};

  // ---- alternate function hooks
  assign force_en_v = {{(NUM_LINES-1){1'b0}}, pulse_output_enable} << `IOPC_LINE_PB7; // (R14)
  assign force_val_v = {{(NUM_LINES-1){1'b0}}, pwm_out} << `IOPC_LINE_PB7; // (R14)
  assign sub_en_v = {{(NUM_LINES-1){1'b0}}, uart_tx_active} << `IOPC_LINE_PB0; // (R19)
  assign sub_val_v = {{(NUM_LINES-1){1'b0}}, uart_tx_bit} << `IOPC_LINE_PB0; // (R19)
  assign od_en_v = {{(NUM_LINES-1){1'b0}}, spi_out_en} << `IOPC_LINE_PA7; // (R17)
  assign od_val_v = {{(NUM_LINES-1){1'b0}}, spi_out_bit} << `IOPC_LINE_PA7; // (R17)

  // ---- one decoder per line
  genvar i;
  generate
    for (i = 0; i < NUM_LINES; i = i + 1) begin : g_line
      iopc_line #(
        .PRESENT(PRESENT_MASK[i]),
        .ANALOG_OK(ANALOG_MASK[i])
      ) u_line (
        .core_clk(core_clk),
        .rstn(rstn),
        .dir(dir_all[i]),
        .opt(opt_all[i]),
        .dat(val_all[i]),
        .pin_in(pin_in[i]),
        .force_en(force_en_v[i]),
        .force_val(force_val_v[i]),
        .sub_en(sub_en_v[i]),
        .sub_val(sub_val_v[i]),
        .od_en(od_en_v[i]),
        .od_val(od_val_v[i]),
        .pin_out(pin_out[i]),
        .pin_oe_n(pin_oe_n[i]),
        .pull_up_en(pull_up_en[i]),
        .analog_en(analog_sel[i]),
        .irq_route(irq_route[i]),
        .read_val(read_all[i]),
        .ev_fall(ev_fall[i]),
        .ev_rise(ev_rise[i]),
        .ev_low(ev_low[i])
      ); // (R22)
      if (i < 8) begin : g_a
        assign ev_sel[i] = trig_sel(trig_q[`IOPC_TRIG_A_LSB+1:`IOPC_TRIG_A_LSB],
                                    ev_fall[i], ev_rise[i], ev_low[i]); // (R7)
      end else if (i < 16) begin : g_b
        assign ev_sel[i] = trig_sel(trig_q[`IOPC_TRIG_B_LSB+1:`IOPC_TRIG_B_LSB],
                                    ev_fall[i], ev_rise[i], ev_low[i]); // (R7)
      end else begin : g_c
        assign ev_sel[i] = trig_sel(trig_q[`IOPC_TRIG_C_LSB+1:`IOPC_TRIG_C_LSB],
                                    ev_fall[i], ev_rise[i], ev_low[i]); // (R7)
      end
    end
  endgenerate

  // ---- registered requests and peripheral input taps
  always @(posedge core_clk) begin
    if (!rstn) begin
      port_event_q <= 3'h0;
      reload_timer_in_pin_q <= 1'b0;
      spi_sin_q <= 1'b0;
      spi_sclk_q <= 1'b0;
      uart_rx_q <= 1'b0;
    end else begin
      port_event_q <= {|ev_sel[23:16], |ev_sel[15:8], |ev_sel[7:0]}; // (R7)
      reload_timer_in_pin_q <= pin_in[`IOPC_LINE_PB6]; // (R15)
      spi_sin_q <= pin_in[`IOPC_LINE_PA6]; // (R16)
      spi_sclk_q <= pin_in[`IOPC_LINE_PA5]; // (R16)
      uart_rx_q <= pin_in[`IOPC_LINE_PB1]; // (R18)
    end
  end

endmodule // iopc_top

// File: testbench/iopc_props.sv
// checker for the i/o port line configuration block
`timescale 1ns/100ps
module iopc_props #(
  parameter NUM_LINES = 24,
  parameter ANALOG_MASK = 24'hf0ff00
) (
  // clock and reset
  input logic core_clk,
  input logic rstn,
  // bus
  input logic avs_waitrequest,
  // pins
  input logic [NUM_LINES-1:0] pin_in,
  input logic [NUM_LINES-1:0] pin_out,
  input logic [NUM_LINES-1:0] pin_oe_n,
  input logic [NUM_LINES-1:0] pull_up_en,
  input logic [NUM_LINES-1:0] analog_sel,
  input logic [NUM_LINES-1:0] irq_route,
  input logic [2:0] port_event_q,
  // alternate functions
  input logic pulse_output_enable,
  input logic pwm_out,
  input logic reload_timer_in_pin_q,
  input logic spi_sin_q,
  input logic spi_sclk_q,
  input logic uart_rx_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  AST_ONE_WAIT: assert property (avs_waitrequest |=> !avs_waitrequest)
    else $error("bus stalled longer than one cycle");
  AST_TAPS: assert property ($past(rstn) |-> {reload_timer_in_pin_q, spi_sin_q, spi_sclk_q, uart_rx_q}
    == $past({pin_in[14], pin_in[6], pin_in[5], pin_in[9]})) else $error("input tap mismatch");
  AST_PWM: assert property (pulse_output_enable |-> !pin_oe_n[15] && pin_out[15] == pwm_out)
    else $error("pwm not on line 15");
  AST_PULL_IN: assert property ((pull_up_en & ~pin_oe_n) == 0)
    else $error("pull-up on driven line");
  AST_IRQ_IN: assert property ((irq_route & ~(pull_up_en & pin_oe_n)) == 0)
    else $error("irq on line without pull-up input");
  AST_ANALOG: assert property ((analog_sel & (~ANALOG_MASK | pull_up_en | ~pin_oe_n)) == 0)
    else $error("bad analog selection");
  AST_EVENT_SRC: assert property ((port_event_q & ~$past({|irq_route[23:16], |irq_route[15:8],
    |irq_route[7:0]})) == 0) else $error("event on port with no routed line");
  AST_RESET_OUT: assert property (!$past(rstn) |-> irq_route == 0 && analog_sel == 0
    && port_event_q == 0 && &(pin_oe_n | 24'h8000)) else $error("outputs not at reset state");
endmodule // iopc_props
bind iopc_top iopc_props #(.NUM_LINES(NUM_LINES), .ANALOG_MASK(ANALOG_MASK)) u_iopc_props (.core_clk, .rstn,
  .avs_waitrequest, .pin_in, .pin_out, .pin_oe_n, .pull_up_en, .analog_sel, .irq_route, .port_event_q,
  .pulse_output_enable, .pwm_out, .reload_timer_in_pin_q, .spi_sin_q, .spi_sclk_q, .uart_rx_q);

// File: testbench/iopc_pins_model.sv
// external circuits on the port pins
`timescale 1ns/100ps
module iopc_pins_model (
  // clock
  input logic core_clk,
  // device pin controls
  input logic [23:0] pin_out,
  input logic [23:0] pin_oe_n,
  input logic [23:0] pull_up_en,
  // external drivers
  input logic [23:0] ext_drv,
  input logic [23:0] ext_val,
  // resolved pin level
  output logic [23:0] pin_lvl
);
  logic [23:0] flt_q = '0;
  // undriven lines without pull-up wander every cycle
  always @(posedge core_clk) flt_q <= ~flt_q;
  assign pin_lvl = (~pin_oe_n & pin_out) | (pin_oe_n & ext_drv & ext_val)
    | (pin_oe_n & ~ext_drv & (pull_up_en | flt_q));
endmodule // iopc_pins_model

// File: testbench/iopc_top_test.sv
// self-checking bench for the i/o port line configuration block
`timescale 1ns/100ps
`include "iopc_consts.vh"
module iopc_top_test;
  logic core_clk = 0;
  logic rstn = 0;
  logic [9:0] avs_address = '0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [23:0] pin_in, pin_out, pin_oe_n, pull_up_en, analog_sel, irq_route;
  logic [23:0] ext_drv = 24'h000f04;
  logic [23:0] ext_val = 24'h000504;
  logic [2:0] port_event_q;
  logic pulse_output_enable = 0, pwm_out = 0, spi_out_en = 0, spi_out_bit = 0, uart_tx_active = 0, uart_tx_bit = 0;
  logic reload_timer_in_pin_q, spi_sin_q, spi_sclk_q, uart_rx_q;
  logic [7:0] rq;
  int error_cnt = 0;
  int num_checks = 0;
  iopc_top u_iopc_top (.core_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .pin_in, .pin_out, .pin_oe_n, .pull_up_en, .analog_sel, .irq_route,
    .port_event_q, .pulse_output_enable, .pwm_out, .reload_timer_in_pin_q, .spi_out_en, .spi_out_bit,
    .spi_sin_q, .spi_sclk_q, .uart_tx_active, .uart_tx_bit, .uart_rx_q);
  iopc_pins_model u_iopc_pins_model (.core_clk, .pin_out, .pin_oe_n, .pull_up_en, .ext_drv, .ext_val,
    .pin_lvl(pin_in));
  initial forever #5 core_clk = ~core_clk;
  task wrap_up;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task cmp(input logic [23:0] g, input logic [23:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task acc(input bit w, input logic [7:0] i, input logic [7:0] d);
    int n;
    @(posedge core_clk);
    avs_address <= {i, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      cmp(1, 0);
      wrap_up;
    end
    rq = avs_readdata[7:0];
    avs_write <= 0;
    avs_read <= 0;
  endtask
  task settle;
    @(posedge core_clk);
    #1;
  endtask
  task count(output int c);
    c = 0;
    repeat (4) begin
      settle;
      c += port_event_q[0] === 1'b1;
    end
  endtask
  task t_reset;
    logic [7:0] ix [10] = '{`IOPC_IDX_VAL_A, `IOPC_IDX_VAL_B, `IOPC_IDX_VAL_C, `IOPC_IDX_DIR_A, `IOPC_IDX_DIR_B,
      `IOPC_IDX_DIR_C, `IOPC_IDX_OPT_A, `IOPC_IDX_OPT_B, `IOPC_IDX_OPT_C, `IOPC_IDX_TRIG};
    logic [7:0] ex [10] = '{8'hfc, 8'hf5, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    cmp(pull_up_en, 24'hfffffc);
    cmp(pin_oe_n, 24'hffffff);
    for (int k = 0; k < 10; k++) begin
      acc(0, ix[k], 0);
      cmp(rq, ex[k]);
    end
  endtask
  task t_modes;
    acc(1, `IOPC_IDX_DIR_B, 8'hf0);
    acc(1, `IOPC_IDX_OPT_B, 8'hcc);
    acc(1, `IOPC_IDX_VAL_B, 8'haa);
    settle;
    cmp(pull_up_en[15:8], 8'h05);
    cmp(irq_route[15:8], 8'h04);
    cmp(analog_sel[15:8], 8'h08);
    cmp(pin_oe_n[15:8], 8'h2f);
    cmp(pin_out[15:8] & ~pin_oe_n[15:8], 8'h80);
    acc(0, `IOPC_IDX_VAL_B, 0);
    cmp(rq, 8'ha5);
    acc(1, `IOPC_IDX_VAL_B, rq | 8'h02);
    settle;
    cmp({irq_route[15:8], analog_sel[15:8]}, 16'h0804);
    // whole shadow copy written back restores the intended input modes
    acc(1, `IOPC_IDX_VAL_B, 8'haa);
    settle;
    cmp({irq_route[15:8], analog_sel[15:8]}, 16'h0408);
  endtask
  task t_events;
    int f, r;
    bit ok;
    acc(1, `IOPC_IDX_OPT_A, 8'h04);
    for (int m = 0; m < 4; m++) begin
      acc(1, `IOPC_IDX_TRIG, m[7:0]);
      repeat (3) settle;
      @(posedge core_clk) ext_val[2] <= 1'b0;
      count(f);
      @(posedge core_clk) ext_val[2] <= 1'b1;
      count(r);
      ok = m == 0 ? f == 1 && r == 0 : m == 1 ? f == 0 && r == 1 : m == 2 ? f >= 3 && r <= 1 : f + r == 0;
      cmp(ok, 1);
    end
  endtask
  task t_alt;
    @(posedge core_clk) pulse_output_enable <= 1;
    for (int v = 0; v < 2; v++) begin
      @(posedge core_clk) pwm_out <= v[0];
      settle;
      cmp({pin_oe_n[15], pin_out[15]}, {1'b0, v[0]});
    end
    @(posedge core_clk) pulse_output_enable <= 0;
    ext_drv <= 24'h004264;
    // timer input line must be an input before its tap is used
    acc(1, `IOPC_IDX_DIR_B, 8'hb1);
    for (int v = 0; v < 2; v++) begin
      @(posedge core_clk) ext_val <= v ? 24'h000224 : 24'h004044;
      repeat (2) settle;
      cmp({reload_timer_in_pin_q, uart_rx_q, spi_sin_q, spi_sclk_q}, v ? 4'h5 : 4'ha);
    end
    acc(1, `IOPC_IDX_OPT_B, 8'h01);
    acc(1, `IOPC_IDX_VAL_B, 8'h01);
    for (int v = 0; v < 2; v++) begin
      @(posedge core_clk) uart_tx_active <= !v;
      settle;
      cmp({pin_oe_n[8], pin_out[8]}, {1'b0, v[0]});
    end
    acc(1, `IOPC_IDX_DIR_A, 8'h80);
    acc(1, `IOPC_IDX_VAL_A, 8'h80);
    spi_out_en <= 1;
    for (int v = 0; v < 2; v++) begin
      acc(1, `IOPC_IDX_OPT_A, v ? 8'h84 : 8'h04);
      settle;
      cmp({pin_oe_n[7], pin_out[7]}, {1'b0, v[0]});
    end
  endtask
  task t_bus;
    acc(1, 8'hc2, 8'h5a);
    acc(0, 8'hc2, 0);
    cmp(rq, 0);
    avs_byteenable <= 4'he;
    acc(1, `IOPC_IDX_DIR_C, 8'hff);
    avs_byteenable <= 4'hf;
    acc(0, `IOPC_IDX_DIR_C, 0);
    cmp(rq, 0);
    cmp(pin_oe_n[23:16], 8'hff);
    // port a lacks lines 0 and 1, software masks them after a whole read
    acc(0, `IOPC_IDX_VAL_A, 0);
    cmp(rq & 8'hfc, 8'hbc);
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    rstn <= 1;
    t_reset;
    t_modes;
    t_events;
    t_alt;
    t_bus;
    wrap_up;
  end
endmodule // iopc_top_test
